// ==== rx_route_pkg.sv ====
// package: register map, field layout and frame class codes of the receive channel router
package rx_route_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CHAN_N = 8;
  localparam int unsigned CHAN_W = 3;
  localparam int unsigned DROP_CNT_W = 16;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_MBP_ENABLE = 8'h00;
  localparam logic [7:0] OFS_UCAST_SET  = 8'h04;
  localparam logic [7:0] OFS_UCAST_CLR  = 8'h08;
  localparam logic [7:0] OFS_DROP_CNT   = 8'h0C;
  localparam logic [7:0] OFS_LAST_ROUTE = 8'h10;

  // ****************************************
  // field positions in rx_multi_broad_promisc_enable
  // ****************************************
  localparam int unsigned MCAST_CH_LSB = 0;
  localparam int unsigned MCAST_EN_BIT = 5;
  localparam int unsigned BCAST_CH_LSB = 8;
  localparam int unsigned BCAST_EN_BIT = 13;

  // ****************************************
  // field positions in the last route status register
  // ****************************************
  localparam int unsigned LAST_CH_LSB   = 0;
  localparam int unsigned LAST_KIND_LSB = 4;
  localparam int unsigned LAST_DROP_BIT = 8;
  localparam int unsigned LAST_SEEN_BIT = 9;

  // ****************************************
  // reset values, drop counter step and saturation limit
  // ****************************************
  localparam logic [2:0]  RST_CHAN     = 3'h0;
  localparam logic [7:0]  RST_UCAST_EN = 8'h00;
  localparam logic [31:0] READ_ZERO    = 32'h0000_0000;
  localparam logic [15:0] DROP_ONE     = 16'h0001;
  localparam logic [15:0] DROP_MAX     = 16'hFFFF;

  // ****************************************
  // frame class reported with each routing decision
  // ****************************************
  typedef enum logic [1:0] {
    KIND_NONE  = 2'b00,
    KIND_UCAST = 2'b01,
    KIND_MCAST = 2'b10,
    KIND_BCAST = 2'b11
  } frame_kind_type;

endpackage

// ==== ucast_en_cell.sv ====
// one channel's unicast receive enable with separate set and clear strobes
`timescale 1ns/100ps

module ucast_en_cell (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // one-cycle strobes from the register decode
  input  wire logic set_pulse,
  input  wire logic clr_pulse,
  // current enable
  output logic      en_r
);

  logic en_nxt;

  // set beats clear if both ever arrive together, so no enable is lost
  assign en_nxt = set_pulse ? 1'b1 : (clr_pulse ? 1'b0 : en_r);

  // state holder, cleared by the module reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      en_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
    end
  end

endmodule

// ==== rx_frame_channel_routing.sv ====
// receive frame channel router: steering registers and per-frame channel choice
//
// Function
// - accepted broadcast frames go to the channel in bcast_channel_sel, 0 to 7
// - with mcast_accept_en set, hash-hitting multicast frames go to mcast_channel_sel
// - mcast_channel_sel sits in bits 2:0, plain binary channel number 0 to 7
// - set view bit n is channel n unicast receive enable
// - writing 1 to a set view bit turns that channel's unicast enable on
// - writing 0 to a set view bit leaves that enable alone
// - reading the set view returns all eight unicast enables
// - clear view reads back the enables, writing 1 clears the bit
// - clear view bit n clears channel n enable, 0 changes nothing
// - broadcast frames dropped when bcast_accept_en is 0, routed when 1
`timescale 1ns/100ps

module rx_frame_channel_routing #(
  parameter int unsigned ADDR_W = rx_route_pkg::ADDR_W,
  parameter int unsigned CHAN_N = rx_route_pkg::CHAN_N
) (
  // clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             sys_rst,
  // register port
  input  wire logic [ADDR_W-1:0]                reg_addr,
  input  wire logic [rx_route_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [rx_route_pkg::DATA_W-1:0]  reg_rdata,
  // frame classification from the address filter path
  input  wire logic                             frm_valid,
  input  wire logic                             frm_is_bcast,
  input  wire logic                             frm_is_mcast,
  input  wire logic                             frm_hash_hit,
  input  wire logic                             frm_is_ucast,
  input  wire logic [rx_route_pkg::CHAN_W-1:0]  frm_ucast_chan,
  // decision towards the receive dma channels
  output logic                                  route_valid,
  output logic      [rx_route_pkg::CHAN_W-1:0]  route_chan,
  output logic      [1:0]                       route_kind,
  output logic                                  route_drop,
  // configuration seen by neighbouring logic
  output logic      [CHAN_N-1:0]                ucast_en,
  output logic      [rx_route_pkg::CHAN_W-1:0]  bcast_channel_sel,
  output logic                                  bcast_accept_en,
  output logic      [rx_route_pkg::CHAN_W-1:0]  mcast_channel_sel,
  output logic                                  mcast_accept_en
);

  // ****************************************
  // address decode
  // ****************************************

  // only the low byte of the address selects a register
  wire logic [7:0] addr_lo = 8'(reg_addr);
  wire logic       hit_mbp  = (addr_lo == rx_route_pkg::OFS_MBP_ENABLE);
  wire logic       hit_set  = (addr_lo == rx_route_pkg::OFS_UCAST_SET);
  wire logic       hit_clr  = (addr_lo == rx_route_pkg::OFS_UCAST_CLR);
  wire logic       hit_drop = (addr_lo == rx_route_pkg::OFS_DROP_CNT);
  wire logic       hit_last = (addr_lo == rx_route_pkg::OFS_LAST_ROUTE);

  // write strobes per register
  wire logic wr_mbp = reg_wr & hit_mbp;
  wire logic wr_set = reg_wr & hit_set;
  wire logic wr_clr = reg_wr & hit_clr;

  // ****************************************
  // steering register
  // ****************************************

  logic [2:0] bcast_ch_r;
  logic       bcast_en_r;
  logic [2:0] mcast_ch_r;
  logic       mcast_en_r;

  // field extraction from a write
  wire logic [2:0] bcast_ch_nxt = reg_wdata[rx_route_pkg::BCAST_CH_LSB +: rx_route_pkg::CHAN_W];
  wire logic       bcast_en_nxt = reg_wdata[rx_route_pkg::BCAST_EN_BIT];
  wire logic [2:0] mcast_ch_nxt = reg_wdata[rx_route_pkg::MCAST_CH_LSB +: rx_route_pkg::CHAN_W];
  wire logic       mcast_en_nxt = reg_wdata[rx_route_pkg::MCAST_EN_BIT];

  // plain read/write register; unused bits are not stored at all
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bcast_ch_r <= rx_route_pkg::RST_CHAN;
      bcast_en_r <= 1'b0;
      mcast_ch_r <= rx_route_pkg::RST_CHAN;
      mcast_en_r <= 1'b0;
    end else if (wr_mbp) begin
      bcast_ch_r <= bcast_ch_nxt;
      bcast_en_r <= bcast_en_nxt;
      mcast_ch_r <= mcast_ch_nxt;
      mcast_en_r <= mcast_en_nxt;
    end
  end

  assign bcast_channel_sel = bcast_ch_r;
  assign bcast_accept_en   = bcast_en_r;
  assign mcast_channel_sel = mcast_ch_r;
  assign mcast_accept_en   = mcast_en_r;

  // ****************************************
  // unicast enables, one cell per channel
  // ****************************************

  // strobes carry only the ones of the write, zeros touch nothing
  wire logic [CHAN_N-1:0] ucast_set_pulse = {CHAN_N{wr_set}} & reg_wdata[CHAN_N-1:0];
  wire logic [CHAN_N-1:0] ucast_clr_pulse = {CHAN_N{wr_clr}} & reg_wdata[CHAN_N-1:0];

  for (genvar n = 0; n < CHAN_N; n++) begin : g_ucast
    // bit n of both views maps to channel n
    ucast_en_cell u_cell (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .set_pulse (ucast_set_pulse[n]),
      .clr_pulse (ucast_clr_pulse[n]),
      .en_r      (ucast_en[n])
    );
  end

  // ****************************************
  // frame routing decision
  // ****************************************

  // broadcast checked first: a broadcast address also has the group bit set
  wire logic bcast_take = frm_is_bcast & bcast_en_r;
  wire logic mcast_take = ~frm_is_bcast & frm_is_mcast & frm_hash_hit & mcast_en_r;
  wire logic ucast_take = ~frm_is_bcast & ~frm_is_mcast & frm_is_ucast & ucast_en[frm_ucast_chan];
  wire logic any_take   = bcast_take | mcast_take | ucast_take;

  // channel chosen for the frame
  wire logic [2:0] chan_nxt = frm_is_bcast ? bcast_ch_r :
                              (frm_is_mcast ? mcast_ch_r : frm_ucast_chan);

  // class of the frame as seen here
  wire logic [1:0] kind_nxt = frm_is_bcast ? rx_route_pkg::KIND_BCAST :
                              (frm_is_mcast ? rx_route_pkg::KIND_MCAST :
                              (frm_is_ucast ? rx_route_pkg::KIND_UCAST : rx_route_pkg::KIND_NONE));

  logic       route_valid_r;
  logic       route_drop_r;
  logic [2:0] route_chan_r;
  logic [1:0] route_kind_r;

  // one-cycle decision pulses, data held until the next frame
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      route_valid_r <= 1'b0;
      route_drop_r  <= 1'b0;
      route_chan_r  <= rx_route_pkg::RST_CHAN;
      route_kind_r  <= rx_route_pkg::KIND_NONE;
    end else begin
      route_valid_r <= frm_valid & any_take;
      route_drop_r  <= frm_valid & ~any_take;
      if (frm_valid) begin
        route_chan_r <= chan_nxt;
        route_kind_r <= kind_nxt;
      end
    end
  end

  assign route_valid = route_valid_r;
  assign route_drop  = route_drop_r;
  assign route_chan  = route_chan_r;
  assign route_kind  = route_kind_r;

  // ****************************************
  // drop statistics and last route status
  // ****************************************

  logic [rx_route_pkg::DROP_CNT_W-1:0] drop_cnt_r;
  logic                                seen_r;

  // saturates instead of wrapping, so a busy link never reports a small count
  wire logic drop_inc = route_drop_r & (drop_cnt_r != rx_route_pkg::DROP_MAX);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      drop_cnt_r <= '0;
      seen_r     <= 1'b0;
    end else begin
      if (drop_inc) begin
        drop_cnt_r <= drop_cnt_r + rx_route_pkg::DROP_ONE;
      end
      if (frm_valid) begin
        seen_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // read data
  // ****************************************

  // assembled read words
  wire logic [31:0] rd_mbp  = (32'(bcast_ch_r) << rx_route_pkg::BCAST_CH_LSB) |
                              (32'(bcast_en_r) << rx_route_pkg::BCAST_EN_BIT) |
                              (32'(mcast_ch_r) << rx_route_pkg::MCAST_CH_LSB) |
                              (32'(mcast_en_r) << rx_route_pkg::MCAST_EN_BIT);
  wire logic [31:0] rd_ucast = 32'(ucast_en);
  wire logic [31:0] rd_drop  = 32'(drop_cnt_r);
  wire logic [31:0] rd_last  = (32'(route_chan_r) << rx_route_pkg::LAST_CH_LSB) |
                               (32'(route_kind_r) << rx_route_pkg::LAST_KIND_LSB) |
                               (32'(route_drop_r) << rx_route_pkg::LAST_DROP_BIT) |
                               (32'(seen_r)       << rx_route_pkg::LAST_SEEN_BIT);

  // both unicast views read the same enables; unmapped offsets read zero
  wire logic [31:0] rd_mux = hit_mbp  ? rd_mbp :
                             (hit_set | hit_clr) ? rd_ucast :
                             hit_drop ? rd_drop :
                             hit_last ? rd_last : rx_route_pkg::READ_ZERO;

  logic [31:0] rdata_r;

  // read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_r <= rx_route_pkg::READ_ZERO;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= rx_route_pkg::READ_ZERO;
    end
  end

  assign reg_rdata = rdata_r;

endmodule

// ==== rx_route_properties.sv ====
// checker: port-level assertions of the receive channel router
`timescale 1ns/100ps
module rx_route_properties #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned CHAN_N = 8
) (
  // clock, reset and register port
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  // frame path and configuration
  input wire logic              frm_valid,
  input wire logic              frm_is_bcast,
  input wire logic              frm_is_mcast,
  input wire logic              frm_hash_hit,
  input wire logic              route_valid,
  input wire logic [2:0]        route_chan,
  input wire logic              route_drop,
  input wire logic [CHAN_N-1:0] ucast_en,
  input wire logic [2:0]        bcast_channel_sel,
  input wire logic              bcast_accept_en,
  input wire logic [2:0]        mcast_channel_sel,
  input wire logic              mcast_accept_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // decode of the three steering registers
  // ****************************************
  wire logic set_wr = reg_wr && reg_addr[7:0] == 8'h04;
  wire logic clr_wr = reg_wr && reg_addr[7:0] == 8'h08;
  wire logic mbp_wr = reg_wr && reg_addr[7:0] == 8'h00;
  wire logic uc_rd  = reg_rd && (reg_addr[7:0] == 8'h04 || reg_addr[7:0] == 8'h08);
  wire logic mc_frm = frm_valid && !frm_is_bcast && frm_is_mcast;
  ucast_set_a: assert property (set_wr |=> ucast_en == ($past(ucast_en) | $past(reg_wdata[CHAN_N-1:0])))
    else $error("unicast set write wrong");
  ucast_clr_a: assert property (clr_wr |=> ucast_en == ($past(ucast_en) & ~$past(reg_wdata[CHAN_N-1:0])))
    else $error("unicast clear write wrong");
  ucast_hold_a: assert property (!set_wr && !clr_wr |=> $stable(ucast_en))
    else $error("unicast enables moved without a write");
  ucast_read_a: assert property (uc_rd |=> reg_rdata == 32'($past(ucast_en)))
    else $error("unicast view read wrong");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  mbp_fields_a: assert property (mbp_wr |=> mcast_channel_sel == $past(reg_wdata[2:0])
    && mcast_accept_en == $past(reg_wdata[5]) && bcast_channel_sel == $past(reg_wdata[10:8])
    && bcast_accept_en == $past(reg_wdata[13]))
    else $error("steering fields not taken from write data");
  bcast_route_a: assert property (frm_valid && frm_is_bcast |=> route_valid == $past(bcast_accept_en)
    && (!route_valid || route_chan == $past(bcast_channel_sel)))
    else $error("broadcast routing wrong");
  mcast_route_a: assert property (mc_frm |=> route_valid == ($past(mcast_accept_en) && $past(frm_hash_hit))
    && (!route_valid || route_chan == $past(mcast_channel_sel)))
    else $error("multicast routing wrong");
  one_answer_a: assert property (frm_valid |=> route_valid ^ route_drop)
    else $error("frame not answered exactly once");
  // main scenarios reached
  cover property (frm_valid && frm_is_bcast ##1 route_valid);
  cover property (mc_frm ##1 route_valid);
  cover property (set_wr ##1 clr_wr);
endmodule

bind rx_frame_channel_routing rx_route_properties #(.ADDR_W(ADDR_W), .CHAN_N(CHAN_N)) u_props (.sys_clk,
  .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frm_valid, .frm_is_bcast, .frm_is_mcast,
  .frm_hash_hit, .route_valid, .route_chan, .route_drop, .ucast_en, .bcast_channel_sel, .bcast_accept_en,
  .mcast_channel_sel, .mcast_accept_en);

// ==== frame_source.sv ====
// frame class source standing in for the receive address filter path
`timescale 1ns/100ps
module frame_source (
  // clock
  input wire logic   sys_clk,
  // classification, {bcast, mcast, hash hit, ucast, channel}
  output logic       frm_valid,
  output logic [6:0] frm_cls
);
  initial begin
    frm_valid = 1'b0;
    frm_cls   = 7'h00;
  end
  // one frame; class lines inverted afterwards so stale values never pass for a frame
  task automatic send(input logic [6:0] cls);
    @(posedge sys_clk);
    frm_valid <= 1'b1;
    frm_cls   <= cls;
    @(posedge sys_clk);
    frm_valid <= 1'b0;
    frm_cls   <= ~cls;
  endtask
endmodule

// ==== testbench.sv ====
// self-checking bench of the receive channel router
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, mbp_m = 32'h0000_0000;
  logic [7:0]  ucast_en, uc_m = 8'h00;
  logic [15:0] drop_m = 16'h0000;
  logic [6:0]  frm_cls;
  logic [2:0]  route_chan, bcast_channel_sel, mcast_channel_sel;
  logic [1:0]  route_kind;
  logic        frm_valid, route_valid, route_drop, bcast_accept_en, mcast_accept_en;
  int          err_total = 0;
  int          checks_done = 0;
  always #4 sys_clk = ~sys_clk;
  frame_source u_src (.sys_clk, .frm_valid, .frm_cls);
  rx_frame_channel_routing u_dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .frm_valid, .frm_is_bcast(frm_cls[6]), .frm_is_mcast(frm_cls[5]), .frm_hash_hit(frm_cls[4]),
    .frm_is_ucast(frm_cls[3]), .frm_ucast_chan(frm_cls[2:0]), .route_valid, .route_chan, .route_kind,
    .route_drop, .ucast_en, .bcast_channel_sel, .bcast_accept_en, .mcast_channel_sel, .mcast_accept_en);
  // ****************************************
  // expectations from the bench's own register image
  // ****************************************
  function automatic logic [5:0] exp_rt(input logic [6:0] c);
    if (c[6]) return {mbp_m[13], mbp_m[10:8], 2'b11};
    if (c[5]) return {mbp_m[5] & c[4], mbp_m[2:0], 2'b10};
    if (c[3]) return {uc_m[c[2:0]], c[2:0], 2'b01};
    return {1'b0, c[2:0], 2'b00};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    if (a == 8'h00) mbp_m = d & 32'h0000_2727;
    if (a == 8'h04) uc_m = uc_m | d[7:0];
    if (a == 8'h08) uc_m = uc_m & ~d[7:0];
    #1 `CHK("ucast_en", uc_m, ucast_en)
    `CHK("mbp fields", {mbp_m[13], mbp_m[10:8], mbp_m[5], mbp_m[2:0]}, {bcast_accept_en, bcast_channel_sel,
      mcast_accept_en, mcast_channel_sel})
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 `CHK("reg_rdata", ex, reg_rdata)
  endtask
  task automatic frm(input logic [6:0] c);
    logic [5:0] e;
    e = exp_rt(c);
    u_src.send(c);
    #1 `CHK("route_valid", e[5], route_valid)
    `CHK("route_drop", ~e[5], route_drop)
    `CHK("route_chan kind", e[4:0], {route_chan, route_kind})
    if (!e[5]) drop_m++;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100_000;
    err_total++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h8984));
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // reset state, read-only and unmapped places
    rd(8'h00, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h3C, 32'h0000_0000);
    // reserved bits of the set view, zero writes to both views change nothing
    wr(8'h04, 32'hFFFF_FF00);
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0000_00FF);
    wr(8'h08, 32'h0000_0000);
    wr(8'h08, 32'h0000_0081);
    rd(8'h08, 32'h0000_007E);
    // every broadcast and multicast channel code, both enables on
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, 32'h0000_2020 | 32'(i << 8) | 32'(7 - i));
      frm(7'h40);
      frm(7'h30);
      frm(7'h08 | 7'(i));
    end
    // random mix of steering writes, view reads and frames
    for (int n = 0; n < 300; n++) begin
      case ($urandom_range(4))
        0: wr(8'h04, $urandom());
        1: wr(8'h08, $urandom());
        2: wr(8'h00, $urandom());
        3: rd($urandom_range(1) ? 8'h04 : 8'h08, {24'h00_0000, uc_m});
        default: frm(7'($urandom()));
      endcase
    end
    // every filtered frame counted once by the statistics register
    rd(8'h0C, {16'h0000, drop_m});
    // second reset in mid-run: steering state and counters back to zero
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    mbp_m  = 32'h0000_0000;
    uc_m   = 8'h00;
    drop_m = 16'h0000;
    rd(8'h04, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0000);
    frm(7'h40);
    complete_run();
  end
endmodule
